/* hw/tct_pkg.sv */
// constants shared by the timer/counter timebase and its pin sampler
// assumes one oscillator clock that also clocks the register bus
package tct_pkg;

   // ****************************************
   // register bus and map
   // ****************************************
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] A_T01_CTRL = 11'h410;
   localparam logic [ADDR_W-1:0] A_T01_XSTAT = 11'h411;
   localparam logic [ADDR_W-1:0] A_T2_CTRL = 11'h418;
   localparam logic [ADDR_W-1:0] A_T2_MODE = 11'h419;
   localparam logic [ADDR_W-1:0] A_SYS_CFG = 11'h440;
   localparam logic [ADDR_W-1:0] A_T0_LO = 11'h450;
   localparam logic [ADDR_W-1:0] A_T0_HI = 11'h451;
   localparam logic [ADDR_W-1:0] A_T1_LO = 11'h452;
   localparam logic [ADDR_W-1:0] A_T1_HI = 11'h453;
   localparam logic [ADDR_W-1:0] A_RLD0_LO = 11'h454;
   localparam logic [ADDR_W-1:0] A_RLD0_HI = 11'h455;
   localparam logic [ADDR_W-1:0] A_RLD1_LO = 11'h456;
   localparam logic [ADDR_W-1:0] A_RLD1_HI = 11'h457;
   localparam logic [ADDR_W-1:0] A_T2_LO = 11'h458;
   localparam logic [ADDR_W-1:0] A_T2_HI = 11'h459;
   localparam logic [ADDR_W-1:0] A_CAP_LO = 11'h45a;
   localparam logic [ADDR_W-1:0] A_CAP_HI = 11'h45b;
   localparam logic [ADDR_W-1:0] A_T01_MODE = 11'h45c;

   // ****************************************
   // field positions
   // ****************************************
   localparam int B_TF1 = 7;
   localparam int B_TR1 = 6;
   localparam int B_TF0 = 5;
   localparam int B_TR0 = 4;
   localparam int B_IE1 = 3;
   localparam int B_IT1 = 2;
   localparam int B_IE0 = 1;
   localparam int B_IT0 = 0;
   localparam int B_TF2 = 7;
   localparam int B_TIMER2_EXTERNAL_FLAG = 6;
   localparam int B_UART0_RX_CLOCK_SEL = 5;
   localparam int B_UART0_TX_CLOCK_SEL = 4;
   localparam int B_TIMER2_EXTERNAL_ENABLE = 3;
   localparam int B_TR2 = 2;
   localparam int B_CT2 = 1;
   localparam int B_CPRL2 = 0;
   localparam int B_UART1_RX_CLOCK_SEL = 5;
   localparam int B_UART1_TX_CLOCK_SEL = 4;
   localparam int B_TIMER2_OUTPUT_ENABLE = 1;
   localparam int B_DOWN_COUNT_ENABLE = 0;
   localparam int B_TIMER1_OUTPUT_ENABLE = 2;
   localparam int B_TIMER0_OUTPUT_ENABLE = 0;
   localparam int B_GATE = 3;
   localparam int B_CT = 2;
   localparam int B_MODE = 0;
   localparam int NIB1 = 4;
   localparam int B_PS = 2;
   localparam logic [7:0] MASK_XSTAT = 8'h05;
   localparam logic [7:0] MASK_TIMER2_MODE = 8'h33;
   localparam logic [7:0] MASK_SCR = 8'h0c;
   localparam logic [7:0] RST_BYTE = 8'h00;

   // ****************************************
   // encodings and counts
   // ****************************************
   localparam logic [1:0] PS_DIV4 = 2'h0;
   localparam logic [1:0] PS_DIV16 = 2'h1;
   localparam int PRE_W = 6;
   localparam logic [PRE_W:0] DIV4 = 7'h04;
   localparam logic [PRE_W:0] DIV16 = 7'h10;
   localparam logic [PRE_W:0] DIV64 = 7'h40;
   localparam logic [1:0] MODE_RELOAD16 = 2'h0;
   localparam logic [1:0] MODE_WRAP16 = 2'h1;
   localparam logic [1:0] MODE_RELOAD8 = 2'h2;
   localparam logic [1:0] MODE_SPLIT = 2'h3;
   localparam logic [7:0] BYTE_MAX = 8'hff;
   localparam logic [15:0] WORD_MAX = 16'hffff;

   // external inputs, one sampler channel each
   localparam int N_CH = 6;
   localparam int CH_T0 = 0;
   localparam int CH_T1 = 1;
   localparam int CH_T2 = 2;
   localparam int CH_INT0 = 3;
   localparam int CH_INT1 = 4;
   localparam int CH_T2EX = 5;

   // sampling period in oscillator cycles; CLK_SYS is the oscillator
   localparam int SAMPLE_PERIOD_OSC = 2;
   localparam int OSC_PER_CLK = 1;
   localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_OSC / OSC_PER_CLK;
   localparam logic SAMPLE_LAST = 1'(SAMPLE_CYCLES - 1);

endpackage

/* hw/tct_samp_if.sv */
// sampled external input levels and falling-edge pulses
// assumes both ends share CLK_SYS
interface tct_samp_if #(parameter int N = 6);
   logic [N-1:0] level;
   logic [N-1:0] fall;
   modport src(output level, output fall);
   modport dst(input level, input fall);
endinterface

/* hw/tct_sampler.sv */
// three-flop synchroniser and periodic sampler for external inputs
// assumes pins are asynchronous to clk
module tct_sampler #(
   parameter int N = 6
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // raw pins
   input wire logic [N-1:0] pins,
   // sampled results
   tct_samp_if.src sp
);
   import tct_pkg::*;

   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] s3;
      logic [N-1:0] flt;
      logic [N-1:0] lvl;
      logic [N-1:0] fall;
      logic ph;
   } tct_samp_t;

   tct_samp_t st;
   tct_samp_t next_st;
   logic strobe;
   logic [N-1:0] agree;

   always_comb begin
      next_st = st;
      next_st.s1 = pins;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      strobe = (st.ph == SAMPLE_LAST);
      next_st.ph = strobe ? 1'b0 : ~st.ph;
      // a change is taken only once the last two stages agree; the agreed level
      // is kept every clock so a two-clock level cannot slip between strobes
      agree = ~(st.s2 ^ st.s3);
      next_st.flt = (agree & st.s3) | (~agree & st.flt);
      next_st.fall = '0;
      if (strobe) begin
         next_st.fall = st.lvl & ~st.flt;
         next_st.lvl = st.flt;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // pins idle high; starting there keeps reset from looking like an edge
         st <= '{s1: '1, s2: '1, s3: '1, flt: '1, lvl: '1, fall: '0, ph: '0};
      end else begin
         st <= next_st;
      end
   end

   assign sp.level = st.lvl;
   assign sp.fall = st.fall;

endmodule

/* hw/tct_timebase.sv */
// timebase, register set and counters for three 16-bit timer/counters
// assumes an 8-bit register bus on CLK_SYS, which is the oscillator
module tct_timebase (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // register bus
   input wire logic [tct_pkg::ADDR_W-1:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire logic [tct_pkg::DATA_W-1:0] SFR_WDATA,
   output logic [tct_pkg::DATA_W-1:0] SFR_RDATA,
   output logic SFR_RVALID,
   // external inputs
   input wire logic T0_IN,
   input wire logic T1_IN,
   input wire logic T2_IN,
   input wire logic INT0_N,
   input wire logic INT1_N,
   input wire logic T2EX_IN,
   // outputs
   output logic [2:0] TIMER_OUT,
   output logic [3:0] UART_CLK_SEL,
   output logic TIMER_BASE_TICK
);
   import tct_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [7:0] timer01_control;
      logic [7:0] timer01_extended_status;
      logic [7:0] timer2_control;
      logic [7:0] timer2_mode;
      logic [7:0] timer01_mode;
      logic [7:0] system_config_register;
      logic [15:0] t0;
      logic [15:0] t1;
      logic [15:0] t2;
      logic [15:0] cap2;
      logic [15:0] rld0;
      logic [15:0] rld1;
      logic [PRE_W-1:0] pre;
      logic tick;
      logic [2:0] tout;
      logic [7:0] rdata;
      logic rvalid;
   } tct_state_t;

   tct_state_t st;
   tct_state_t next_st;

   tct_samp_if #(.N(N_CH)) samp ();

   tct_sampler #(.N(N_CH)) u_sampler (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .pins({T2EX_IN, INT1_N, INT0_N, T2_IN, T1_IN, T0_IN}),
      .sp(samp)
   );

   // one count step for timers 0 and 1; bit 16 is the overflow
   function automatic logic [16:0] tct_step(input logic [1:0] mode, input logic [15:0] c,
                                            input logic [15:0] r);
      logic [16:0] res;
      res = {1'b0, c};
      unique case (mode)
         MODE_RELOAD16: begin
            res = (c == WORD_MAX) ? {1'b1, r} : {1'b0, c + 16'h0001};
         end
         MODE_WRAP16: begin
            res = {c == WORD_MAX, c + 16'h0001};
         end
         MODE_RELOAD8: begin
            res = (c[7:0] == BYTE_MAX) ? {1'b1, c[15:8], r[7:0]} :
                                         {1'b0, c[15:8], c[7:0] + 8'h01};
         end
         MODE_SPLIT: begin
            res = {c[7:0] == BYTE_MAX, c[15:8], c[7:0] + 8'h01};
         end
      endcase
      return res;
   endfunction

   // ****************************************
   // next-state logic
   // ****************************************
   logic [PRE_W:0] div;
   logic [1:0] m0;
   logic [1:0] m1;
   logic run0;
   logic run1;
   logic src0;
   logic src1;
   logic inc2;
   logic down2;
   logic [16:0] r0;
   logic [16:0] r1;
   logic split_ovf;
   logic [2:0] ovf;
   logic [7:0] set01;
   logic [7:0] set2;
   logic [7:0] rd;

   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      next_st.rvalid = 1'b0;
      r0 = '0;
      r1 = '0;
      split_ovf = 1'b0;
      ovf = '0;
      set01 = '0;
      set2 = '0;
      rd = RST_BYTE;

      // ****************************************
      // prescaler
      // ****************************************
      // reserved setting runs at the slowest rate rather than stopping
      unique case (st.system_config_register[B_PS +: 2])
         PS_DIV4: div = DIV4;
         PS_DIV16: div = DIV16;
         default: div = DIV64;
      endcase
      if ({1'b0, st.pre} >= div - 7'h01) begin
         next_st.pre = '0;
         next_st.tick = 1'b1;
      end else begin
         next_st.pre = st.pre + 6'h01;
      end

      // ****************************************
      // timers 0 and 1
      // ****************************************
      m0 = st.timer01_mode[B_MODE +: 2];
      m1 = st.timer01_mode[NIB1 + B_MODE +: 2];
      // gate lets the irq pin (active low, pin high = enabled) qualify run
      run0 = st.timer01_control[B_TR0] & (~st.timer01_mode[B_GATE] | samp.level[CH_INT0]);
      run1 = st.timer01_control[B_TR1] & (~st.timer01_mode[NIB1 + B_GATE] | samp.level[CH_INT1]);
      src0 = st.timer01_mode[B_CT] ? samp.fall[CH_T0] : st.tick;
      src1 = st.timer01_mode[NIB1 + B_CT] ? samp.fall[CH_T1] : st.tick;
      if (run0 && src0) begin
         r0 = tct_step(m0, st.t0, st.rld0);
         next_st.t0 = r0[15:0];
         ovf[0] = r0[16];
      end
      // split mode: high byte of timer 0 borrows timer 1 run and flag
      if (m0 == MODE_SPLIT && st.timer01_control[B_TR1] && st.tick) begin
         next_st.t0[15:8] = st.t0[15:8] + 8'h01;
         split_ovf = (st.t0[15:8] == BYTE_MAX);
      end
      // timer 1 in split mode just holds its count
      if (m1 != MODE_SPLIT && run1 && src1) begin
         r1 = tct_step(m1, st.t1, st.rld1);
         next_st.t1 = r1[15:0];
         ovf[1] = r1[16];
      end
      set01[B_TF0] = ovf[0];
      // while timer 0 is split, timer 1 may still clock a uart but flags nothing
      set01[B_TF1] = (m0 == MODE_SPLIT) ? split_ovf : ovf[1];
      set01[B_IE0] = st.timer01_control[B_IT0] ? samp.fall[CH_INT0] : ~samp.level[CH_INT0];
      set01[B_IE1] = st.timer01_control[B_IT1] ? samp.fall[CH_INT1] : ~samp.level[CH_INT1];

      // ****************************************
      // timer 2
      // ****************************************
      inc2 = st.timer2_control[B_TR2] & (st.timer2_control[B_CT2] ? samp.fall[CH_T2] : st.tick);
      // down-counting only when enabled, direction from the T2EX level
      down2 = st.timer2_mode[B_DOWN_COUNT_ENABLE] & ~samp.level[CH_T2EX];
      if (inc2) begin
         if (down2) begin
            if (st.t2 == st.cap2) begin
               next_st.t2 = WORD_MAX;
               ovf[2] = 1'b1;
            end else begin
               next_st.t2 = st.t2 - 16'h0001;
            end
         end else if (st.t2 == WORD_MAX) begin
            next_st.t2 = st.timer2_control[B_CPRL2] ? 16'h0000 : st.cap2;
            ovf[2] = 1'b1;
         end else begin
            next_st.t2 = st.t2 + 16'h0001;
         end
      end
      if (st.timer2_control[B_TIMER2_EXTERNAL_ENABLE] && samp.fall[CH_T2EX]) begin
         set2[B_TIMER2_EXTERNAL_FLAG] = 1'b1;
         if (st.timer2_control[B_CPRL2]) begin
            next_st.cap2 = st.t2;
         end else if (!st.timer2_mode[B_DOWN_COUNT_ENABLE]) begin
            next_st.t2 = st.cap2;
         end
      end
      set2[B_TF2] = ovf[2];

      // output toggles on overflow when enabled
      next_st.tout[0] = st.tout[0] ^ (ovf[0] & st.timer01_extended_status[B_TIMER0_OUTPUT_ENABLE]);
      next_st.tout[1] = st.tout[1] ^ (ovf[1] & st.timer01_extended_status[B_TIMER1_OUTPUT_ENABLE]);
      next_st.tout[2] = st.tout[2] ^ (ovf[2] & st.timer2_mode[B_TIMER2_OUTPUT_ENABLE]);

      // ****************************************
      // register writes
      // ****************************************
      // bus is byte-wide by construction, so only one byte lands per write
      if (SFR_WR) begin
         case (SFR_ADDR)
            A_T01_CTRL: next_st.timer01_control = SFR_WDATA;
            A_T01_XSTAT: next_st.timer01_extended_status = SFR_WDATA & MASK_XSTAT;
            A_T2_CTRL: next_st.timer2_control = SFR_WDATA;
            A_T2_MODE: next_st.timer2_mode = SFR_WDATA & MASK_TIMER2_MODE;
            A_SYS_CFG: next_st.system_config_register = SFR_WDATA & MASK_SCR;
            A_T01_MODE: next_st.timer01_mode = SFR_WDATA;
            A_T0_LO: next_st.t0[7:0] = SFR_WDATA;
            A_T0_HI: next_st.t0[15:8] = SFR_WDATA;
            A_T1_LO: next_st.t1[7:0] = SFR_WDATA;
            A_T1_HI: next_st.t1[15:8] = SFR_WDATA;
            A_RLD0_LO: next_st.rld0[7:0] = SFR_WDATA;
            A_RLD0_HI: next_st.rld0[15:8] = SFR_WDATA;
            A_RLD1_LO: next_st.rld1[7:0] = SFR_WDATA;
            A_RLD1_HI: next_st.rld1[15:8] = SFR_WDATA;
            A_T2_LO: next_st.t2[7:0] = SFR_WDATA;
            A_T2_HI: next_st.t2[15:8] = SFR_WDATA;
            A_CAP_LO: next_st.cap2[7:0] = SFR_WDATA;
            A_CAP_HI: next_st.cap2[15:8] = SFR_WDATA;
            default: ;
         endcase
      end
      // a hardware event in the cycle of a clearing write still sets its flag
      next_st.timer01_control = next_st.timer01_control | set01;
      next_st.timer2_control = next_st.timer2_control | set2;

      // ****************************************
      // register reads
      // ****************************************
      // reads only copy state, so counting carries on untouched
      case (SFR_ADDR)
         A_T01_CTRL: rd = st.timer01_control;
         A_T01_XSTAT: rd = st.timer01_extended_status;
         A_T2_CTRL: rd = st.timer2_control;
         A_T2_MODE: rd = st.timer2_mode;
         A_SYS_CFG: rd = st.system_config_register;
         A_T01_MODE: rd = st.timer01_mode;
         A_T0_LO: rd = st.t0[7:0];
         A_T0_HI: rd = st.t0[15:8];
         A_T1_LO: rd = st.t1[7:0];
         A_T1_HI: rd = st.t1[15:8];
         A_RLD0_LO: rd = st.rld0[7:0];
         A_RLD0_HI: rd = st.rld0[15:8];
         A_RLD1_LO: rd = st.rld1[7:0];
         A_RLD1_HI: rd = st.rld1[15:8];
         A_T2_LO: rd = st.t2[7:0];
         A_T2_HI: rd = st.t2[15:8];
         A_CAP_LO: rd = st.cap2[7:0];
         A_CAP_HI: rd = st.cap2[15:8];
         default: rd = RST_BYTE;
      endcase
      if (SFR_RD) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rd;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign SFR_RDATA = st.rdata;
   assign SFR_RVALID = st.rvalid;
   assign TIMER_OUT = st.tout;
   assign UART_CLK_SEL = {st.timer2_mode[B_UART1_RX_CLOCK_SEL], st.timer2_mode[B_UART1_TX_CLOCK_SEL],
                          st.timer2_control[B_UART0_RX_CLOCK_SEL], st.timer2_control[B_UART0_TX_CLOCK_SEL]};
   assign TIMER_BASE_TICK = st.tick;

endmodule

/* tb/tct_ev_src.sv */
// far-side model: event source on the three counter input pins
// assumes start is a one-cycle pulse given while busy is low
module tct_ev_src (
   // clock
   input wire logic clk,
   // request
   input wire logic start,
   input wire logic [7:0] n_fall,
   // pins and status
   output logic [2:0] pins = 3'h7,
   output logic busy = 1'b0
);
   // ****************************************
   // falling edges at the fastest legal rate
   // ****************************************
   // pins idle high, like the port pull-ups
   always @(posedge clk) begin
      if (start && !busy) begin
         busy <= 1'b1;
         repeat (n_fall) begin
            pins <= 3'h0;
            repeat (2) @(posedge clk);
            pins <= 3'h7;
            repeat (2) @(posedge clk);
         end
         busy <= 1'b0;
      end
   end
endmodule

/* tb/tct_timebase_checker.sv */
// port-level assertions for the timer timebase
// assumes one oscillator clock and a synchronous active-low reset
module tct_timebase_checker (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // register bus
   input wire logic [tct_pkg::ADDR_W-1:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire logic [tct_pkg::DATA_W-1:0] SFR_WDATA,
   input wire logic [tct_pkg::DATA_W-1:0] SFR_RDATA,
   input wire logic SFR_RVALID,
   // outputs
   input wire logic [2:0] TIMER_OUT,
   input wire logic [3:0] UART_CLK_SEL,
   input wire logic TIMER_BASE_TICK
);
   import tct_pkg::*;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   // ****************************************
   // sequences
   // ****************************************
   sequence s_read_req;
      SFR_RD;
   endsequence
   sequence s_unmapped_rd;
      SFR_RD && SFR_ADDR == 11'h400;
   endsequence
   sequence s_t2ctrl_wr;
      SFR_WR && SFR_ADDR == A_T2_CTRL;
   endsequence
   sequence s_t2mode_wr;
      SFR_WR && SFR_ADDR == A_T2_MODE;
   endsequence

   // ****************************************
   // assertions
   // ****************************************
   a_read_answered: assert property (s_read_req |=> SFR_RVALID)
      else $error("read not answered next cycle");
   a_answer_cause: assert property (SFR_RVALID |-> $past(SFR_RD))
      else $error("read answer without request");
   a_rdata_holds: assert property (!SFR_RVALID |-> $stable(SFR_RDATA))
      else $error("read data moved without answer");
   a_unmapped_zero: assert property (s_unmapped_rd |=> SFR_RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_tick_min_gap: assert property (TIMER_BASE_TICK |=> !TIMER_BASE_TICK [*3])
      else $error("base tick closer than four clocks");
   a_tick_max_gap: assert property (TIMER_BASE_TICK |=> ##[0:63] TIMER_BASE_TICK)
      else $error("base tick gap above sixty four");
   a_reset_clears: assert property ($rose(RST_N) |-> TIMER_OUT == 3'h0
      && UART_CLK_SEL == 4'h0 && !TIMER_BASE_TICK)
      else $error("outputs not clear after reset");
   a_uart0_select: assert property (s_t2ctrl_wr |=>
      UART_CLK_SEL[1:0] == $past(SFR_WDATA[5:4]))
      else $error("uart0 clock selects wrong");
   a_uart1_select: assert property (s_t2mode_wr |=>
      UART_CLK_SEL[3:2] == $past(SFR_WDATA[5:4]))
      else $error("uart1 clock selects wrong");
   a_select_steady: assert property (!SFR_WR |=> $stable(UART_CLK_SEL))
      else $error("clock selects moved without write");
endmodule

bind tct_timebase tct_timebase_checker i_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
   .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA),
   .SFR_RDATA(SFR_RDATA), .SFR_RVALID(SFR_RVALID), .TIMER_OUT(TIMER_OUT),
   .UART_CLK_SEL(UART_CLK_SEL), .TIMER_BASE_TICK(TIMER_BASE_TICK));

/* tb/testbench.sv */
// self-checking bench for the timer timebase
// assumes the event source model and the bound checker
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import tct_pkg::*;
   logic clk_sys, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rvalid, tick, ev_start = 1'b0, busy;
   logic [ADDR_W-1:0] addr = 11'h000;
   logic [7:0] wdata = 8'h00, rdata, rb;
   logic [2:0] pins, tout;
   logic [3:0] usel;
   logic t2ex = 1'b1;
   int bad_count, compares;

   tct_timebase i_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .SFR_ADDR(addr), .SFR_WR(wr),
      .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata), .SFR_RVALID(rvalid),
      .T0_IN(pins[0]), .T1_IN(pins[1]), .T2_IN(pins[2]), .INT0_N(1'b1), .INT1_N(1'b1),
      .T2EX_IN(t2ex), .TIMER_OUT(tout), .UART_CLK_SEL(usel), .TIMER_BASE_TICK(tick));
   tct_ev_src i_src (.clk(clk_sys), .start(ev_start), .n_fall(8'h05), .pins(pins),
      .busy(busy));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic do_reset();
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
   endtask
   // byte accesses only, the bus has no wider path
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1;
      chk("read answer", 8'h01, {7'h00, rvalid});
      d = rdata;
   endtask
   task automatic expect_reg(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd_reg(a, d);
      chk($sformatf("register %h", a), e, d);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic s_reset_values();
      logic [ADDR_W-1:0] regs [18] = '{A_T01_CTRL, A_T01_XSTAT, A_T2_CTRL, A_T2_MODE,
         A_SYS_CFG, A_T0_LO, A_T0_HI, A_T1_LO, A_T1_HI, A_RLD0_LO, A_RLD0_HI, A_RLD1_LO,
         A_RLD1_HI, A_T2_LO, A_T2_HI, A_CAP_LO, A_CAP_HI, A_T01_MODE};
      foreach (regs[i]) expect_reg(regs[i], 8'h00);
      chk("clock selects", 8'h00, {4'h0, usel});
   endtask
   task automatic s_field_layout();
      wr_reg(A_T01_XSTAT, 8'hff);
      expect_reg(A_T01_XSTAT, 8'h05);
      wr_reg(A_T2_MODE, 8'hff);
      expect_reg(A_T2_MODE, 8'h33);
      chk("clock selects", 8'h0c, {4'h0, usel});
      wr_reg(A_T2_CTRL, 8'h30);
      expect_reg(A_T2_CTRL, 8'h30);
      chk("clock selects", 8'h0f, {4'h0, usel});
      wr_reg(A_T01_CTRL, 8'h05);
      expect_reg(A_T01_CTRL, 8'h05);
      wr_reg(A_T01_MODE, 8'ha5);
      expect_reg(A_T01_MODE, 8'ha5);
      wr_reg(11'h400, 8'hff);
      expect_reg(11'h400, 8'h00);
      wr_reg(A_T01_XSTAT, 8'h00);
      wr_reg(A_T2_MODE, 8'h00);
      wr_reg(A_T2_CTRL, 8'h00);
      wr_reg(A_T01_CTRL, 8'h00);
      wr_reg(A_T01_MODE, 8'h00);
   endtask
   task automatic s_prescale();
      logic [7:0] div [3] = '{8'h04, 8'h10, 8'h40};
      int n;
      for (int i = 0; i < 3; i++) begin
         wr_reg(A_SYS_CFG, 8'(i << 2));
         // first gap may be cut short by the change of setting
         repeat (2) begin
            n = 0;
            do begin
               @(posedge clk_sys);
               #1;
               n++;
            end while (tick !== 1'b1 && n < 200);
         end
         chk("tick spacing", div[i], 8'(n));
      end
   endtask
   task automatic s_overflow_modes();
      logic [7:0] exp_lo [3] = '{8'h55, 8'h00, 8'h55};
      logic [7:0] exp_hi [3] = '{8'h66, 8'h00, 8'h12};
      int n;
      wr_reg(A_RLD0_LO, 8'h55);
      wr_reg(A_RLD0_HI, 8'h66);
      wr_reg(A_T01_XSTAT, 8'h01);
      for (int m = 0; m < 3; m++) begin
         wr_reg(A_T01_MODE, 8'(m));
         wr_reg(A_T0_LO, 8'hfe);
         wr_reg(A_T0_HI, m == 2 ? 8'h12 : 8'hff);
         wr_reg(A_T01_CTRL, 8'h10);
         n = 0;
         // polls run while counting; the overflow must still arrive
         do begin
            rd_reg(A_T01_CTRL, rb);
            n++;
         end while (rb[B_TF0] !== 1'b1 && n < 200);
         chk("overflow flag", 8'h01, {7'h00, rb[B_TF0]});
         chk("timer output", {7'h00, ~m[0]}, {7'h00, tout[0]});
         expect_reg(A_T0_LO, exp_lo[m]);
         expect_reg(A_T0_HI, exp_hi[m]);
         wr_reg(A_T01_CTRL, 8'h00);
      end
   endtask
   task automatic run_events();
      int n;
      @(posedge clk_sys);
      ev_start <= 1'b1;
      @(posedge clk_sys);
      ev_start <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (busy !== 1'b0 && n < 100);
      // synchroniser, filter, sample strobe and count step need up to seven clocks
      repeat (10) @(posedge clk_sys);
   endtask
   task automatic s_event_count();
      wr_reg(A_T01_MODE, 8'h55);
      wr_reg(A_T0_LO, 8'h00);
      wr_reg(A_T0_HI, 8'h00);
      wr_reg(A_T2_CTRL, 8'h06);
      wr_reg(A_T01_CTRL, 8'h50);
      run_events();
      expect_reg(A_T0_LO, 8'h05);
      expect_reg(A_T1_LO, 8'h05);
      expect_reg(A_T2_LO, 8'h05);
      // timer 2 counts down only with its enable set and the direction pin low
      @(posedge clk_sys);
      t2ex <= 1'b0;
      wr_reg(A_T2_MODE, 8'h01);
      wr_reg(A_T2_LO, 8'h10);
      run_events();
      expect_reg(A_T2_LO, 8'h0b);
      expect_reg(A_T2_HI, 8'h00);
      @(posedge clk_sys);
      t2ex <= 1'b1;
   endtask

   // ****************************************
   // run and verdict
   // ****************************************
   task automatic tally_and_finish();
      if (bad_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #200000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      do_reset();
      s_reset_values();
      s_field_layout();
      s_prescale();
      s_overflow_modes();
      s_event_count();
      do_reset();
      s_reset_values();
      tally_and_finish();
   end
endmodule
